// >>> design/rsr_regs.svh
// Register offsets, reset values and timing counts for the reset sequencer
`ifndef RSR_REGS_SVH
`define RSR_REGS_SVH

`define RSR_ADDR_CTRL        12'h000
`define RSR_ADDR_STATUS      12'h004
`define RSR_ADDR_CAUSE       12'h008
`define RSR_ADDR_PORTS       12'h00c
`define RSR_ADDR_CORE        12'h010

`define RSR_CTRL_MON_EN      0
`define RSR_CTRL_STOP_REQ    1

`define RSR_PROG_CNT_RST     10'h000
`define RSR_TMR_RST          10'h000
`define RSR_DPTR_RST         8'h00
`define RSR_PORT0_RST        8'hff
`define RSR_PORT1_LOW_RST    4'hf
`define RSR_CTRLA_RST        8'h03
`define RSR_CTRLB_RST        8'h26

`define RSR_WAIT_MIN         10'd246
`define RSR_WAIT_MAX         10'd694
`define RSR_WAIT_DEF         10'd256

`endif

// >>> design/rsr_pkg.sv
// Types shared by the reset and stop release sequencer
`default_nettype none
package rsr_pkg;
    typedef enum logic [2:0] {
        RSR_ST_RESET = 3'b000,
        RSR_ST_WAIT  = 3'b001,
        RSR_ST_RUN   = 3'b010,
        RSR_ST_STOP  = 3'b011,
        RSR_ST_SWAIT = 3'b100
    } rsr_state_t;
endpackage
`default_nettype wire

// >>> design/rsr_sync.sv
// Two flip-flop synchroniser, one per bit
`timescale 1ns/10ps
`default_nettype none
module rsr_sync #(
    parameter int W = 1
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_reset_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_ff;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_core_clk) begin
                if (!i_reset_n) begin
                    meta_ff[g] <= 1'b0;
                    o_sync[g]  <= 1'b0;
                end else begin
                    meta_ff[g] <= i_async[g];
                    o_sync[g]  <= meta_ff[g];
                end
            end
        end
    endgenerate
endmodule // rsr_sync
`default_nettype wire

// >>> design/rsr_seq.sv
// Reset gathering, stabilisation wait and stop release sequencer
//
// Contract
// - STOP release enters a counted wait
// - Release gone after wait returns to STOP
// - Low reset pin resets whole system
// - Pin low stops oscillator, grounds pins
// - Count 246..694 clocks then fetch zero
// - Supply monitor reset drives pin low
// - Pin and supply monitor reset ORed
// - Reset clears counter, timer, flags, pointer
// - Ports and controls load fixed values, except port one high nibble, which loads the keys
// - Memory kept over standby reset only
// - Illegal standby instruction resets
// - Rotate with zero accumulator resets
// - Stack overflow or underflow resets
// - Release after wait sets status flag
// - Oscillator stops in reset or STOP
`timescale 1ns/10ps
`default_nettype none
`include "rsr_regs.svh"
module rsr_seq #(
    parameter logic [9:0] WAIT_CYCLES = `RSR_WAIT_DEF
) (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_reset_n,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Reset pin as open drain, and supply monitor
    input  wire logic        i_reset_pin_n,
    output logic             o_reset_pin_out,
    output logic             o_reset_pin_oe,
    input  wire logic        i_supply_monitor_reset,
    // Key inputs and standby release
    input  wire logic [3:0]  i_key_input_pins,
    // Internal reset events from the core, one-cycle pulses
    input  wire logic        i_halt_illegal,
    input  wire logic        i_rotate_zero_check_instr,
    input  wire logic [3:0]  i_accumulator,
    input  wire logic        i_stack_overflow,
    input  wire logic        i_stack_underflow,
    // Core state outputs
    output logic             o_osc_run,
    output logic             o_osc_input_pin_gnd,
    output logic             o_core_run,
    output logic             o_core_reset,
    output logic             o_retain_mem,
    output logic [9:0]       o_program_counter,
    output logic [9:0]       o_timer,
    output logic             o_stack_pointer,
    output logic             o_status_flag,
    output logic             o_carry_flag,
    output logic [7:0]       o_data_pointer,
    output logic [7:0]       o_port_reg_zero,
    output logic [7:0]       o_port_reg_one,
    output logic [7:0]       o_control_reg_a,
    output logic [7:0]       o_control_reg_b
);
    rsr_pkg::rsr_state_t state_ff;
    rsr_pkg::rsr_state_t nxt_state;
    logic [9:0] cnt_ff;
    logic [3:0] key_s;
    logic       pin_low_s;
    logic       mon_s;
    logic       mon_en_ff;
    logic       stop_req_ff;
    logic [3:0] cause_ff;
    logic       any_rst;
    logic       int_rst;
    logic       release_cond;
    logic       wr_stb;
    logic       rd_stb;

    // Pin, supply monitor and keys pass two flip-flops
    rsr_sync #(.W(6)) u_sync (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_async    ({~i_reset_pin_n, i_supply_monitor_reset,
                      i_key_input_pins}),
        .o_sync     ({pin_low_s, mon_s, key_s})
    );

    assign int_rst = i_halt_illegal
                   | (i_rotate_zero_check_instr && i_accumulator == 4'h0)
                   | i_stack_overflow | i_stack_underflow;
    // pin and monitor ORed; pin resets all
    assign any_rst = pin_low_s | (mon_s & mon_en_ff) | int_rst;
    assign release_cond = |key_s;

    assign wr_stb = i_psel & i_penable & i_pwrite;
    assign rd_stb = i_psel & ~i_penable & ~i_pwrite;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            rsr_pkg::RSR_ST_RESET: begin
                if (!any_rst) begin
                    nxt_state = rsr_pkg::RSR_ST_WAIT;
                end
            end
            rsr_pkg::RSR_ST_WAIT: begin
                if (cnt_ff == WAIT_CYCLES - 10'd1) begin
                    nxt_state = rsr_pkg::RSR_ST_RUN;
                end
            end
            rsr_pkg::RSR_ST_RUN: begin
                if (stop_req_ff && !release_cond) begin
                    nxt_state = rsr_pkg::RSR_ST_STOP;
                end
            end
            rsr_pkg::RSR_ST_STOP: begin
                if (release_cond) begin
                    nxt_state = rsr_pkg::RSR_ST_SWAIT;
                end
            end
            rsr_pkg::RSR_ST_SWAIT: begin
                if (cnt_ff == WAIT_CYCLES - 10'd1) begin
                    nxt_state = release_cond ? rsr_pkg::RSR_ST_RUN
                                             : rsr_pkg::RSR_ST_STOP;
                end
            end
            default: nxt_state = rsr_pkg::RSR_ST_RESET;
        endcase
        if (any_rst) begin
            nxt_state = rsr_pkg::RSR_ST_RESET;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            state_ff <= rsr_pkg::RSR_ST_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            cnt_ff <= 10'h000;
        end else if (nxt_state != state_ff) begin
            cnt_ff <= 10'h000;
        end else begin
            cnt_ff <= cnt_ff + 10'd1;
        end
    end

    // oscillator stopped in reset and STOP
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_osc_run           <= 1'b0;
            o_osc_input_pin_gnd <= 1'b1;
            o_core_run          <= 1'b0;
            o_core_reset        <= 1'b1;
        end else begin
            o_osc_run <= nxt_state != rsr_pkg::RSR_ST_RESET
                      && nxt_state != rsr_pkg::RSR_ST_STOP;
            o_osc_input_pin_gnd <= nxt_state == rsr_pkg::RSR_ST_RESET;
            o_core_run   <= nxt_state == rsr_pkg::RSR_ST_RUN;
            o_core_reset <= nxt_state == rsr_pkg::RSR_ST_RESET
                         || nxt_state == rsr_pkg::RSR_ST_WAIT;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_reset_pin_out <= 1'b0;
            o_reset_pin_oe  <= 1'b0;
        end else begin
            o_reset_pin_out <= 1'b0;
            o_reset_pin_oe  <= mon_s & mon_en_ff;
        end
    end

    // memory retained when reset hits standby
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_retain_mem <= 1'b0;
        end else if (any_rst && state_ff != rsr_pkg::RSR_ST_RESET) begin
            o_retain_mem <= state_ff == rsr_pkg::RSR_ST_STOP
                         || state_ff == rsr_pkg::RSR_ST_SWAIT;
        end
    end

    // post-reset core state; flag on release
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || nxt_state == rsr_pkg::RSR_ST_RESET) begin
            o_program_counter <= `RSR_PROG_CNT_RST;
            o_timer           <= `RSR_TMR_RST;
            o_stack_pointer   <= 1'b0;
            o_status_flag     <= 1'b0;
            o_carry_flag      <= 1'b0;
            o_data_pointer    <= `RSR_DPTR_RST;
            o_port_reg_zero   <= `RSR_PORT0_RST;
            o_port_reg_one    <= {key_s, `RSR_PORT1_LOW_RST};
            o_control_reg_a   <= `RSR_CTRLA_RST;
            o_control_reg_b   <= `RSR_CTRLB_RST;
        end else if (state_ff == rsr_pkg::RSR_ST_SWAIT
                     && nxt_state == rsr_pkg::RSR_ST_RUN) begin
            o_status_flag <= 1'b1;
        end
    end

    // Control register and cause capture; set wins over clear
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            mon_en_ff   <= 1'b1;
            stop_req_ff <= 1'b0;
            cause_ff    <= 4'h0;
        end else begin
            if (wr_stb && i_paddr == `RSR_ADDR_CTRL) begin
                mon_en_ff   <= i_pwdata[`RSR_CTRL_MON_EN];
                stop_req_ff <= i_pwdata[`RSR_CTRL_STOP_REQ];
            end else if (nxt_state == rsr_pkg::RSR_ST_STOP) begin
                stop_req_ff <= 1'b0;
            end
            cause_ff <= ((wr_stb && i_paddr == `RSR_ADDR_CAUSE)
                         ? cause_ff & ~i_pwdata[3:0] : cause_ff)
                      | {i_stack_overflow | i_stack_underflow,
                         i_rotate_zero_check_instr && i_accumulator == 4'h0,
                         i_halt_illegal, pin_low_s | mon_s};
        end
    end

    // APB: zero wait in access, read data registered in setup
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable
                       & (i_paddr > `RSR_ADDR_CORE || i_paddr[1:0] != 2'b00);
            if (rd_stb) begin
                case (i_paddr)
                    `RSR_ADDR_CTRL:
                        o_prdata <= {30'h0, stop_req_ff, mon_en_ff};
                    `RSR_ADDR_STATUS:
                        o_prdata <= {23'h0, o_retain_mem, key_s,
                                     1'b0, state_ff};
                    `RSR_ADDR_CAUSE:
                        o_prdata <= {28'h0, cause_ff};
                    `RSR_ADDR_PORTS:
                        o_prdata <= {o_control_reg_b, o_control_reg_a,
                                     o_port_reg_one, o_port_reg_zero};
                    `RSR_ADDR_CORE:
                        o_prdata <= {10'h0, o_status_flag, o_carry_flag,
                                     o_timer, o_program_counter};
                    default: o_prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    property p_wait_len;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        WAIT_CYCLES >= `RSR_WAIT_MIN && WAIT_CYCLES <= `RSR_WAIT_MAX;
    endproperty
    a_wait_len: assert property (p_wait_len)
        else $error("wait length outside range");

    property p_rst_state;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        any_rst |=> state_ff == rsr_pkg::RSR_ST_RESET && !o_osc_run;
    endproperty
    a_rst_state: assert property (p_rst_state)
        else $error("reset did not stop system");

    property p_pc_clear;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        any_rst |=> o_program_counter == `RSR_PROG_CNT_RST && !o_status_flag
                    && o_port_reg_zero == `RSR_PORT0_RST;
    endproperty
    a_pc_clear: assert property (p_pc_clear)
        else $error("post reset state wrong");

    property p_pin_drive;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (mon_s && mon_en_ff) |=> o_reset_pin_oe && !o_reset_pin_out;
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("reset pin not driven low");

    property p_rotate;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (i_rotate_zero_check_instr && i_accumulator == 4'h0)
            |=> o_core_reset;
    endproperty
    a_rotate: assert property (p_rotate)
        else $error("rotate zero reset missed");

    property p_stop_osc;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        state_ff == rsr_pkg::RSR_ST_STOP |-> !o_osc_run;
    endproperty
    a_stop_osc: assert property (p_stop_osc)
        else $error("oscillator runs in stop");

    property p_release;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (state_ff == rsr_pkg::RSR_ST_STOP && release_cond && !any_rst)
            |=> state_ff == rsr_pkg::RSR_ST_SWAIT;
    endproperty
    a_release: assert property (p_release)
        else $error("stop release not taken");

    property p_restop;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (state_ff == rsr_pkg::RSR_ST_SWAIT && nxt_state != state_ff
         && !release_cond && !any_rst)
            |=> state_ff == rsr_pkg::RSR_ST_STOP;
    endproperty
    a_restop: assert property (p_restop)
        else $error("no return to stop");

    property p_flag;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (state_ff == rsr_pkg::RSR_ST_SWAIT
         && nxt_state == rsr_pkg::RSR_ST_RUN) |=> o_status_flag;
    endproperty
    a_flag: assert property (p_flag)
        else $error("status flag not set");
endmodule // rsr_seq
`default_nettype wire

// >>> sim/rsr_ext_model.sv
// External reset circuit and key matrix facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module rsr_ext_model (
    // Clock
    input  wire logic       i_core_clk,
    // Device drive of the open drain reset pin
    input  wire logic       i_reset_pin_out,
    input  wire logic       i_reset_pin_oe,
    // Bench request to pull the pin low
    input  wire logic       i_ext_low,
    // Pins seen by the device
    output logic            o_reset_pin_n,
    output logic      [3:0] o_key_input_pins
);
    // Pulled up wire, any low driver wins
    assign o_reset_pin_n = !((i_reset_pin_oe && !i_reset_pin_out)
                             || i_ext_low);

    initial o_key_input_pins = 4'h0;

    task automatic press(input int len);
        o_key_input_pins <= 4'h1;
        repeat (len) @(posedge i_core_clk);
        o_key_input_pins <= 4'h0;
        @(posedge i_core_clk);
    endtask
endmodule // rsr_ext_model
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the reset and stop release sequencer
`timescale 1ns/10ps
`default_nettype none
`include "rsr_regs.svh"
module testbench;
    logic        clk = 1'b0;
    logic        rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pin_n, pin_out, pin_oe, mon, ext_low, e;
    logic [3:0]  keys, acc;
    logic        halt, rot, ovf, unf, osc_run, osc_gnd, core_run;
    logic        core_rst, retain, stk, flag, carry;
    logic [9:0]  prog_cnt, tmr;
    logic [7:0]  dptr, port0, port1, ca, cb;
    int          err_total = 0;
    int          tests_run = 0;
    int          n;

    always #2 clk = ~clk;

    rsr_seq #(.WAIT_CYCLES(10'd246)) rsr_seq_i (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_reset_pin_n(pin_n),
        .o_reset_pin_out(pin_out), .o_reset_pin_oe(pin_oe),
        .i_supply_monitor_reset(mon), .i_key_input_pins(keys),
        .i_halt_illegal(halt), .i_rotate_zero_check_instr(rot),
        .i_accumulator(acc), .i_stack_overflow(ovf),
        .i_stack_underflow(unf), .o_osc_run(osc_run),
        .o_osc_input_pin_gnd(osc_gnd), .o_core_run(core_run),
        .o_core_reset(core_rst), .o_retain_mem(retain),
        .o_program_counter(prog_cnt), .o_timer(tmr), .o_stack_pointer(stk),
        .o_status_flag(flag), .o_carry_flag(carry), .o_data_pointer(dptr),
        .o_port_reg_zero(port0), .o_port_reg_one(port1),
        .o_control_reg_a(ca), .o_control_reg_b(cb));

    rsr_ext_model rsr_ext_model_i (
        .i_core_clk(clk), .i_reset_pin_out(pin_out),
        .i_reset_pin_oe(pin_oe), .i_ext_low(ext_low),
        .o_reset_pin_n(pin_n), .o_key_input_pins(keys));

    task automatic summarize();
        $display("Checks %0d, errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_run();
        n = 0;
        while (core_run !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n >= 246 && n <= 694), 32'h1);
    endtask

    task automatic chk_post();
        chk({prog_cnt, tmr, stk, flag, carry, dptr}, 32'h0);
        chk({port0, port1, ca, cb}, {`RSR_PORT0_RST, 4'h0,
            `RSR_PORT1_LOW_RST, `RSR_CTRLA_RST, `RSR_CTRLB_RST});
    endtask

    task automatic pin_reset();
        ext_low <= 1'b1;
        repeat (10) @(posedge clk);
        chk({core_rst, core_run, osc_run, osc_gnd}, 32'h9);
        ext_low <= 1'b0;
        @(posedge clk);
        wait_run();
        chk_post();
    endtask

    initial begin
        repeat (10000) @(posedge clk);
        err_total++;
        summarize();
    end

    initial begin
        rst_n <= 1'b0;
        {psel, penable, pwrite, paddr, pwdata} <= '0;
        {mon, ext_low, halt, rot, ovf, unf, acc} <= '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wait_run();
        chk_post();
        pin_reset();
        chk(retain, 1'b0);
        // Clear the pin cause so the monitor must set it again
        apb(1'b1, `RSR_ADDR_CAUSE, 32'hf);
        mon <= 1'b1;
        repeat (8) @(posedge clk);
        chk({pin_oe, pin_out, pin_n, core_rst}, 32'h9);
        mon <= 1'b0;
        @(posedge clk);
        wait_run();
        apb(1'b0, `RSR_ADDR_CAUSE, 32'h0);
        chk(q[0], 1'b1);
        apb(1'b1, `RSR_ADDR_CAUSE, 32'hf);
        apb(1'b0, 12'h014, 32'h0);
        chk(e, 1'b1);
        apb(1'b0, 12'h002, 32'h0);
        chk(e, 1'b1);
        // Monitor disabled: no pin drive, no reset
        apb(1'b1, `RSR_ADDR_CTRL, 32'h0);
        mon <= 1'b1;
        repeat (8) @(posedge clk);
        chk({pin_oe, core_run}, 32'h1);
        mon <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1'b1, `RSR_ADDR_CTRL, 32'h1);
        apb(1'b0, `RSR_ADDR_CTRL, 32'h0);
        chk(q, 32'h1);
        apb(1'b0, `RSR_ADDR_STATUS, 32'h0);
        chk(q[2:0], rsr_pkg::RSR_ST_RUN);
        chk(e, 1'b0);
        acc <= 4'h5;
        rot <= 1'b1;
        @(posedge clk);
        rot <= 1'b0;
        repeat (4) @(posedge clk);
        chk(core_run, 1'b1);
        acc <= 4'h0;
        for (int i = 0; i < 4; i++) begin
            halt <= (i == 0);
            rot  <= (i == 1);
            ovf  <= (i == 2);
            unf  <= (i == 3);
            @(posedge clk);
            {halt, rot, ovf, unf} <= 4'h0;
            @(posedge clk);
            chk({core_rst, osc_run}, 32'h2);
            wait_run();
            chk_post();
            apb(1'b0, `RSR_ADDR_CAUSE, 32'h0);
            chk(q[3:1], (i < 2) ? (3'h1 << i) : 3'h4);
            apb(1'b1, `RSR_ADDR_CAUSE, 32'hf);
        end
        apb(1'b1, `RSR_ADDR_CTRL, 32'h3);
        repeat (4) @(posedge clk);
        chk({osc_run, core_run}, 32'h0);
        rsr_ext_model_i.press(20);
        repeat (300) @(posedge clk);
        chk({osc_run, core_run}, 32'h0);
        fork
            rsr_ext_model_i.press(400);
            wait_run();
        join
        chk(flag, 1'b1);
        apb(1'b1, `RSR_ADDR_CTRL, 32'h3);
        repeat (4) @(posedge clk);
        pin_reset();
        chk(retain, 1'b1);
        summarize();
    end
endmodule // testbench
`default_nettype wire
